// ### rlm_pkg.sv
// constants for the reference clock lock and data rate measurement block
package rlm_pkg;
   // -------------------------------------------------------------
   // register subaddresses
   // -------------------------------------------------------------
   localparam logic [2:0] ADDR_RATE_HIGH   = 3'h0;
   localparam logic [2:0] ADDR_RATE_MID    = 3'h1;
   localparam logic [2:0] ADDR_RATE_LOW    = 3'h2;
   localparam logic [2:0] ADDR_STATUS      = 3'h3;
   localparam logic [2:0] ADDR_MODE_CTRL   = 3'h4;
   localparam logic [2:0] ADDR_RESTART     = 3'h5;
   localparam logic [2:0] ADDR_OPTION      = 3'h6;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int MODE_REF_LOCK_BIT   = 0;
   localparam int MODE_MEAS_EN_BIT    = 1;
   localparam int MODE_RATIO_LSB      = 2;
   localparam int MODE_RANGE_LSB      = 6;
   localparam int RST_MEAS_BIT        = 3;
   localparam int RST_ACQ_BIT         = 5;
   localparam int OPT_LOS_POL_BIT     = 2;
   localparam int STAT_LOL_BIT        = 0;
   localparam int STAT_DONE_BIT       = 2;
   // -------------------------------------------------------------
   // reset values and counts
   // -------------------------------------------------------------
   localparam logic [7:0] MODE_CTRL_RST   = 8'h00;
   localparam logic [7:0] RESTART_RST     = 8'h00;
   localparam logic [7:0] OPTION_RST      = 8'h00;
   localparam int         RESULT_W        = 23;
   localparam int         WIN_BASE_EXP    = 14;
   localparam int         WIN_CNT_W       = 18;
   localparam int         PPM_W           = 12;
   localparam logic [11:0] LOCK_PPM       = 12'h0FA;  // 250 ppm
   localparam logic [11:0] UNLOCK_PPM     = 12'h3E8;  // 1000 ppm
   // measurement sequencer states
   typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_DONE} rlm_meas_state_t;
endpackage : rlm_pkg

// ### rlm_core.sv
// lock detector, mode control and fine data rate measurement
module rlm_core #(
   parameter int RESULT_W = rlm_pkg::RESULT_W
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [2:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             reg_ack_out,
   input  wire logic        los_detect_in,
   input  wire logic        reference_clock_input_in,
   input  wire logic        data_rate_tick_in,
   input  wire logic [11:0] rate_count_result_err_ppm_in,
   output logic             signal_loss_output_out,
   output logic             lock_loss_indication_out,
   output logic             acq_restart_out,
   output logic             ref_lock_cmd_out,
   output logic             ref_lock_mode_out,
   output logic      [1:0]  ref_div_exp_out,
   output logic      [3:0]  data_div_exp_out,
   output logic             rate_valid_out
);
   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   // the readback bytes carry exactly 23 result bits
   if (RESULT_W != rlm_pkg::RESULT_W)
   begin : g_bad_width
      $error("result width must be 23");
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // last reference edge index of a window of 2^(14+range)
   function automatic logic [rlm_pkg::WIN_CNT_W-1:0] rlm_win_last(input logic [1:0] range);
      logic [rlm_pkg::WIN_CNT_W-1:0] one;
      one = {{(rlm_pkg::WIN_CNT_W-1){1'b0}}, 1'b1};
      return (one << (rlm_pkg::WIN_BASE_EXP + int'(range))) - one;
   endfunction : rlm_win_last

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   logic [2:0] los_sync_ff;
   logic [2:0] ref_sync_ff;
   logic [2:0] dat_sync_ff;
   logic       los_lvl_ff;
   logic       ref_lvl_ff;
   logic       dat_lvl_ff;

   // three stages; a level is taken only once stages two and three agree
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         los_sync_ff <= 3'h0;
         ref_sync_ff <= 3'h0;
         dat_sync_ff <= 3'h0;
      end
      else
      begin
         los_sync_ff <= {los_sync_ff[1:0], los_detect_in};
         ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_input_in};
         dat_sync_ff <= {dat_sync_ff[1:0], data_rate_tick_in};
      end
   end

   wire los_agree = los_sync_ff[1] == los_sync_ff[2];
   wire ref_agree = ref_sync_ff[1] == ref_sync_ff[2];
   wire dat_agree = dat_sync_ff[1] == dat_sync_ff[2];

   // filtered levels
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         los_lvl_ff <= 1'b0;
         ref_lvl_ff <= 1'b0;
         dat_lvl_ff <= 1'b0;
      end
      else
      begin
         if (los_agree) los_lvl_ff <= los_sync_ff[2];
         if (ref_agree) ref_lvl_ff <= ref_sync_ff[2];
         if (dat_agree) dat_lvl_ff <= dat_sync_ff[2];
      end
   end

   // rising edges; the inputs are prescaled ticks, well under half the core rate
   wire ref_edge = ref_agree && ref_sync_ff[2] && !ref_lvl_ff;
   wire dat_edge = dat_agree && dat_sync_ff[2] && !dat_lvl_ff;

   // -------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------
   logic [7:0] mode_ctrl_ff;
   logic [7:0] restart_ff;
   logic [7:0] option_ff;
   logic [7:0] mode_prev_ff;
   logic [7:0] restart_prev_ff;

   wire wr_mode    = reg_wr_in && (reg_addr_in == rlm_pkg::ADDR_MODE_CTRL);
   wire wr_restart = reg_wr_in && (reg_addr_in == rlm_pkg::ADDR_RESTART);
   wire wr_option  = reg_wr_in && (reg_addr_in == rlm_pkg::ADDR_OPTION);

   // software writes; other writes never touch the mode fields
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         mode_ctrl_ff    <= rlm_pkg::MODE_CTRL_RST;
         restart_ff      <= rlm_pkg::RESTART_RST;
         option_ff       <= rlm_pkg::OPTION_RST;
         mode_prev_ff    <= rlm_pkg::MODE_CTRL_RST;
         restart_prev_ff <= rlm_pkg::RESTART_RST;
      end
      else
      begin
         if (wr_mode)    mode_ctrl_ff <= reg_wdata_in;
         if (wr_restart) restart_ff   <= reg_wdata_in;
         if (wr_option)  option_ff    <= reg_wdata_in;
         mode_prev_ff    <= mode_ctrl_ff;
         restart_prev_ff <= restart_ff;
      end
   end

   wire       ref_lock_en = mode_ctrl_ff[rlm_pkg::MODE_REF_LOCK_BIT];
   wire       meas_en     = mode_ctrl_ff[rlm_pkg::MODE_MEAS_EN_BIT];
   wire [1:0] range_sel   = mode_ctrl_ff[rlm_pkg::MODE_RANGE_LSB +: 2];
   wire [3:0] ratio_sel   = mode_ctrl_ff[rlm_pkg::MODE_RATIO_LSB +: 4];
   wire       los_pol     = option_ff[rlm_pkg::OPT_LOS_POL_BIT];

   // restart acts on the 1-to-0 step only
   wire acq_fall  = restart_prev_ff[rlm_pkg::RST_ACQ_BIT] && !restart_ff[rlm_pkg::RST_ACQ_BIT];
   wire meas_fall = restart_prev_ff[rlm_pkg::RST_MEAS_BIT] && !restart_ff[rlm_pkg::RST_MEAS_BIT];
   // lock command on the 0-to-1 step
   wire ref_rise  = ref_lock_en && !mode_prev_ff[rlm_pkg::MODE_REF_LOCK_BIT];

   // -------------------------------------------------------------
   // divider settings for the frequency loop
   // -------------------------------------------------------------
   // divider exponents straight from the mode fields
   // range code maps one octave of reference per step
   assign ref_div_exp_out  = range_sel;
   assign data_div_exp_out = ratio_sel;
   // measurement enable plays no part in selecting the lock source
   assign ref_lock_mode_out = ref_lock_en;

   // -------------------------------------------------------------
   // lock detector
   // -------------------------------------------------------------
   logic lol_ff;
   logic acq_restart_ff;
   logic ref_cmd_ff;

   wire within_lock  = rate_count_result_err_ppm_in <= rlm_pkg::LOCK_PPM;
   wire beyond_lock  = rate_count_result_err_ppm_in >  rlm_pkg::UNLOCK_PPM;
   wire lol_lose     = !lol_ff && beyond_lock;
   wire nxt_lol      = acq_fall || lol_lose || (lol_ff && !within_lock);
   // any lock loss re-enters acquisition; the loop picks reference or data source
   wire nxt_acq_rst  = acq_fall || lol_lose;

   // lock state starts lost so the loop acquires after reset
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         lol_ff         <= 1'b1;
         acq_restart_ff <= 1'b0;
         ref_cmd_ff     <= 1'b0;
      end
      else
      begin
         lol_ff         <= nxt_lol;
         acq_restart_ff <= nxt_acq_rst;
         ref_cmd_ff     <= ref_rise;
      end
   end

   assign lock_loss_indication_out = lol_ff;
   assign acq_restart_out          = acq_restart_ff;
   assign ref_lock_cmd_out         = ref_cmd_ff;

   // -------------------------------------------------------------
   // signal loss output
   // -------------------------------------------------------------
   logic los_out_ff;

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         los_out_ff <= 1'b0;
      else
         los_out_ff <= los_lvl_ff ^ los_pol;
   end

   assign signal_loss_output_out = los_out_ff;

   // -------------------------------------------------------------
   // data rate measurement
   // -------------------------------------------------------------
   rlm_pkg::rlm_meas_state_t        meas_state_ff;
   rlm_pkg::rlm_meas_state_t        nxt_meas_state;
   logic [rlm_pkg::WIN_CNT_W-1:0]   win_cnt_ff;
   logic [RESULT_W-1:0]             dat_cnt_ff;
   logic [RESULT_W-1:0]             result_ff;

   // at least 2^14 reference edges keeps the ratio inside 100 ppm
   wire win_end   = (meas_state_ff == rlm_pkg::MS_RUN) && ref_edge && (win_cnt_ff == rlm_win_last(range_sel));
   // enable stays set across repeated starts
   wire meas_go   = meas_en && meas_fall;
   wire dat_full  = &dat_cnt_ff;

   // sequencer: a new start always wins over a finishing window
   always_comb
   begin
      nxt_meas_state = meas_state_ff;
      case (meas_state_ff)
         rlm_pkg::MS_IDLE: if (meas_go) nxt_meas_state = rlm_pkg::MS_RUN;
         rlm_pkg::MS_RUN:  if (!meas_en) nxt_meas_state = rlm_pkg::MS_IDLE;
                           else if (meas_go) nxt_meas_state = rlm_pkg::MS_RUN;
                           else if (win_end) nxt_meas_state = rlm_pkg::MS_DONE;
         rlm_pkg::MS_DONE: if (meas_go) nxt_meas_state = rlm_pkg::MS_RUN;
         default:          nxt_meas_state = rlm_pkg::MS_IDLE;
      endcase
   end

   // count data ticks over the reference window, then latch
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         meas_state_ff <= rlm_pkg::MS_IDLE;
         win_cnt_ff    <= '0;
         dat_cnt_ff    <= '0;
         result_ff     <= '0;
      end
      else
      begin
         meas_state_ff <= nxt_meas_state;
         if (meas_go)
         begin
            win_cnt_ff <= '0;
            dat_cnt_ff <= '0;
         end
         else if (meas_state_ff == rlm_pkg::MS_RUN)
         begin
            if (ref_edge) win_cnt_ff <= win_cnt_ff + 1'b1;
            // saturate rather than wrap to a small wrong figure
            if (dat_edge && !dat_full) dat_cnt_ff <= dat_cnt_ff + 1'b1;
         end
         // window length gives the 2^(14+range) scale
         if (win_end && !meas_go) result_ff <= dat_cnt_ff;
      end
   end

   // done only after the window closes
   wire meas_done = meas_state_ff == rlm_pkg::MS_DONE;
   // the reading is flagged invalid whenever lock is currently lost, whenever it was taken
   assign rate_valid_out = meas_done && !lol_ff;

   // -------------------------------------------------------------
   // register read port
   // -------------------------------------------------------------
   logic [7:0] rdata_ff;
   logic [7:0] status_word;
   logic [7:0] rd_mux;

   assign status_word = {5'h00, meas_done, 1'b0, lol_ff};
   // result split over three bytes, high byte zero-padded
   assign rd_mux =
      (reg_addr_in == rlm_pkg::ADDR_RATE_HIGH) ? {1'b0, result_ff[22:16]} :
      (reg_addr_in == rlm_pkg::ADDR_RATE_MID)  ? result_ff[15:8]          :
      (reg_addr_in == rlm_pkg::ADDR_RATE_LOW)  ? result_ff[7:0]           :
      (reg_addr_in == rlm_pkg::ADDR_STATUS)    ? status_word              :
      (reg_addr_in == rlm_pkg::ADDR_MODE_CTRL) ? mode_ctrl_ff             :
      (reg_addr_in == rlm_pkg::ADDR_RESTART)   ? restart_ff               :
      (reg_addr_in == rlm_pkg::ADDR_OPTION)    ? option_ff                : 8'h00;
   assign reg_ack_out = (reg_wr_in || reg_rd_in) && (reg_addr_in != 3'h7);

   // read data held until the next read
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         rdata_ff <= 8'h00;
      else if (reg_rd_in)
         rdata_ff <= rd_mux;
   end

   assign reg_rdata_out = rdata_ff;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_los_polarity: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      ##1 signal_loss_output_out == ($past(los_lvl_ff) ^ $past(los_pol)))
      else $error("signal loss polarity wrong");
   a_lol_release: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      lol_ff && within_lock && !acq_fall |=> !lock_loss_indication_out)
      else $error("lock loss not released within 250 ppm");
   a_lol_reassert: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      !lol_ff && beyond_lock |=> lock_loss_indication_out && acq_restart_out)
      else $error("lock loss not raised above 1000 ppm");
   a_acq_restart_keep: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      acq_fall && !reg_wr_in |=> acq_restart_out && $stable(mode_ctrl_ff) && $stable(option_ff))
      else $error("acquisition restart missing or modes disturbed");
   a_ref_lock_cmd: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      $rose(ref_lock_mode_out) |=> ref_lock_cmd_out ##1 !ref_lock_cmd_out)
      else $error("lock command not a single pulse");
   a_meas_restart_clr: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      meas_go |=> !meas_done && meas_state_ff == rlm_pkg::MS_RUN && dat_cnt_ff == '0)
      else $error("measurement restart did not clear done");
   a_window_latch: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      win_end && !meas_go && meas_en |=> meas_done && result_ff == $past(dat_cnt_ff))
      else $error("window end did not latch result");
   a_done_held: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      meas_done && meas_en && !meas_fall |=> meas_done && $stable(result_ff))
      else $error("done dropped without restart");
   a_high_byte: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      reg_rd_in && reg_addr_in == rlm_pkg::ADDR_RATE_HIGH |=> reg_rdata_out == {1'b0, $past(result_ff[22:16])})
      else $error("high result byte wrong");
   a_valid_gate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      lock_loss_indication_out |-> !rate_valid_out)
      else $error("result valid during lock loss");
   a_div_fields: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      wr_mode |=> ref_div_exp_out == $past(reg_wdata_in[7:6]) && data_div_exp_out == $past(reg_wdata_in[5:2]))
      else $error("divider exponents not taken from mode write");
   a_cmd_only_rise: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      !ref_rise |=> !ref_lock_cmd_out)
      else $error("lock command without a rising mode bit");
   a_acq_only_event: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      !acq_fall && !lol_lose |=> !acq_restart_out)
      else $error("acquisition restart without cause");
   a_rdata_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");

endmodule : rlm_core

// ### rlm_tick_source.sv
// bench model of the reference oscillator and recovered data tick source
module rlm_tick_source
(
   input  wire logic       core_clk_in,
   input  wire logic [3:0] data_period_in,
   output logic            ref_tick_out,
   output logic            data_tick_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ref_cnt  = 4'h0;
   logic [3:0] data_cnt = 4'h0;
   // -------------------------------------------------------------
   // free running dividers
   // -------------------------------------------------------------
   // reference fits range 00
   // sixth of the core clock: slower than the quarter rate the core's tick sampler accepts, keeps the window short
   always @(posedge core_clk_in)
   begin
      ref_cnt <= (ref_cnt == 4'h5) ? 4'h0 : ref_cnt + 4'h1;
      data_cnt <= (data_cnt >= data_period_in - 4'h1) ? 4'h0 : data_cnt + 4'h1;
   end
   // ticks are plain levels, so they never hold a stale value between edges
   assign ref_tick_out  = (ref_cnt < 4'h3);
   assign data_tick_out = (data_cnt < {1'b0, data_period_in[3:1]});
endmodule : rlm_tick_source

// ### testbench.sv
// self-checking bench for the lock detector and data rate measurement core
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_in     = 1'b0;
   logic        rst_b_in        = 1'b0;
   logic        reg_wr_in       = 1'b0;
   logic        reg_rd_in       = 1'b0;
   logic [2:0]  reg_addr_in     = 3'h0;
   logic [7:0]  reg_wdata_in    = 8'h00;
   logic        los_detect_in   = 1'b0;
   logic [11:0] rate_count_result_err_ppm_in = 12'hFFF;
   logic [3:0]  data_period     = 4'h8;
   wire  logic  ref_tick, data_tick, los_out, lock_loss_indication, acq, cmd, ref_mode, rate_valid, ack_w;
   wire  logic [7:0] rdata;
   wire  logic [1:0] ref_div;
   wire  logic [3:0] data_div;
   int          failures = 0;
   int          checks = 0;
   int          acq_pulses = 0;
   int          cmd_pulses = 0;
   int          a0;
   int          i;
   logic [7:0]  rd;
   logic [7:0]  m;
   logic        ack;
   logic        pol;
   logic [22:0] result;

   rlm_tick_source u_src (.core_clk_in(core_clk_in), .data_period_in(data_period),
      .ref_tick_out(ref_tick), .data_tick_out(data_tick));
   rlm_core u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(rdata), .reg_ack_out(ack_w), .los_detect_in(los_detect_in),
      .reference_clock_input_in(ref_tick), .data_rate_tick_in(data_tick),
      .rate_count_result_err_ppm_in(rate_count_result_err_ppm_in), .signal_loss_output_out(los_out),
      .lock_loss_indication_out(lock_loss_indication), .acq_restart_out(acq), .ref_lock_cmd_out(cmd),
      .ref_lock_mode_out(ref_mode), .ref_div_exp_out(ref_div), .data_div_exp_out(data_div),
      .rate_valid_out(rate_valid));

   always #50 core_clk_in = ~core_clk_in;
   // pulses last one cycle, so count them rather than race to see them
   always @(posedge core_clk_in)
   begin
      acq_pulses <= acq_pulses + ((acq === 1'b1) ? 1 : 0);
      cmd_pulses <= cmd_pulses + ((cmd === 1'b1) ? 1 : 0);
   end
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic check_val(input logic [22:0] got, input logic [22:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val
   task automatic check_near(input logic [22:0] got, input int exp, input int tol);
      checks++;
      if ((^got === 1'bx) || (int'(got) > exp + tol) || (int'(got) + tol < exp))
      begin
         failures++;
         $display("wrong value at %0t: rate count %0d expected near %0d", $time, got, exp);
      end
   endtask : check_near
   // loss pin follows the detector, inverted when the polarity bit is set
   function automatic logic exp_loss_pin(input logic signal_loss_output, input logic p);
      return signal_loss_output ^ p;
   endfunction : exp_loss_pin
   // data ticks seen in a window of 2^(14+range) reference periods
   function automatic int exp_rate_count(input int ref_per, input int dat_per, input int range_code);
      return ((1 << (rlm_pkg::WIN_BASE_EXP + range_code)) * ref_per) / dat_per;
   endfunction : exp_rate_count
   // one strobe per access, released the edge it is taken, then one idle edge
   task automatic reg_access(input logic wr, input logic [2:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = wr;
      reg_rd_in = ~wr;
      #10;
      ack = ack_w;
      tick(1);
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      rd = rdata;
      tick(1);
   endtask : reg_access
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      reg_access(1'b1, a, d);
   endtask : wr_reg
   task automatic rd_check(input logic [2:0] a, input logic [7:0] exp);
      reg_access(1'b0, a, 8'h00);
      check_val({22'h0, ack}, {22'h0, (a != 3'h7)}, "ack");
      check_val({15'h0, rd}, {15'h0, exp}, "read data");
   endtask : rd_check
   task automatic report_and_stop;
      if (failures == 0 && checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // -------------------------------------------------------------
   // watchdog: one full range 00 window plus register traffic
   // -------------------------------------------------------------
   initial
   begin
      #(106000 * 100);
      failures++;
      report_and_stop();
   end
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial
   begin
      void'($urandom(91));
      data_period = 4'(7 + $urandom_range(6));
      tick(5);
      rst_b_in = 1'b1;
      tick(4);
      for (i = 0; i < 8; i++)
      begin
         rd_check(3'(i), (i == 3) ? 8'h01 : 8'h00);
      end
      wr_reg(3'h0, 8'hA5);
      rd_check(3'h0, 8'h00);
      for (i = 0; i < 8; i++)
      begin
         pol = 1'($urandom);
         los_detect_in = 1'($urandom);
         wr_reg(3'h6, {5'h00, pol, 2'h0});
         tick(5);
         check_val({22'h0, los_out}, {22'h0, exp_loss_pin(los_detect_in, pol)}, "loss pin");
      end
      // hysteresis band walk of the lock indication
      rate_count_result_err_ppm_in = 12'(251 + $urandom_range(700));
      tick(3);
      check_val({22'h0, lock_loss_indication}, 23'h1, "lol held high");
      rate_count_result_err_ppm_in = 12'h0FA;
      tick(2);
      check_val({22'h0, lock_loss_indication}, 23'h0, "lol falls");
      rate_count_result_err_ppm_in = 12'h3E8;
      tick(3);
      check_val({22'h0, lock_loss_indication}, 23'h0, "lol held low");
      // acquisition restart keeps every mode setting
      m = {2'($urandom), 4'h5, 2'b00};
      wr_reg(3'h4, m);
      a0 = acq_pulses;
      wr_reg(3'h5, 8'h20);
      wr_reg(3'h5, 8'h00);
      tick(2);
      check_val(23'(acq_pulses - a0), 23'h1, "acq pulse");
      check_val({22'h0, lock_loss_indication}, 23'h1, "lol after restart");
      rd_check(3'h4, m);
      rd_check(3'h6, {5'h00, pol, 2'h0});
      check_val({17'h0, ref_div, data_div}, {17'h0, m[7:2]}, "divider fields");
      // lock command on rising edge of the mode bit only
      a0 = cmd_pulses;
      wr_reg(3'h4, m | 8'h01);
      wr_reg(3'h4, m | 8'h01);
      tick(1);
      check_val(23'(cmd_pulses - a0), 23'h1, "lock command");
      check_val({22'h0, ref_mode}, 23'h1, "ref mode");
      rate_count_result_err_ppm_in = 12'h000;
      tick(2);
      a0 = acq_pulses;
      rate_count_result_err_ppm_in = 12'h3E9;
      tick(2);
      check_val({22'h0, lock_loss_indication}, 23'h1, "lol rises");
      check_val(23'(acq_pulses - a0), 23'h1, "reacquire");
      rate_count_result_err_ppm_in = 12'(  $urandom_range(250));
      tick(2);
      check_val({22'h0, lock_loss_indication}, 23'h0, "relock");
      a0 = cmd_pulses;
      // lock mode off and range set before measuring
      wr_reg(3'h4, 8'h16);
      wr_reg(3'h5, 8'h08);
      wr_reg(3'h5, 8'h00);
      tick(2);
      check_val(23'(cmd_pulses - a0), 23'h0, "no command on clear");
      rd_check(3'h3, 8'h00);
      for (i = 0; i < 100000 && rate_valid !== 1'b1; i++)
      begin
         tick(1);
      end
      rd_check(3'h3, 8'h04);
      reg_access(1'b0, 3'h0, 8'h00);
      check_val({22'h0, rd[7]}, 23'h0, "high byte bit7");
      result[22:16] = rd[6:0];
      reg_access(1'b0, 3'h1, 8'h00);
      result[15:8] = rd;
      reg_access(1'b0, 3'h2, 8'h00);
      result[7:0] = rd;
      // the tick model's reference period is six core cycles
      check_near(result, exp_rate_count(6, int'(data_period), 0), 3);
      check_val({22'h0, rate_valid}, 23'h1, "valid while locked");
      rate_count_result_err_ppm_in = 12'h3E9;
      tick(2);
      check_val({22'h0, rate_valid}, 23'h0, "invalid when lock lost");
      rate_count_result_err_ppm_in = 12'h000;
      tick(2);
      // second run with the enable left set
      wr_reg(3'h5, 8'h08);
      wr_reg(3'h5, 8'h00);
      tick(1);
      rd_check(3'h3, 8'h00);
      rd_check(3'h4, 8'h16);
      wr_reg(3'h4, 8'h14);
      rd_check(3'h3, 8'h00);
      report_and_stop();
   end
endmodule : testbench
